/* verilog/capability_query_table.sv */
// APB slave exposing the burst and page read capability query entries
//
// Functional notes
// - Offset 48h reads 0003h; page size is 2^n bytes, n in low byte.
// - Offset 49h reads 0003h, the count of burst configuration entries.
// - Offset 4Ah reads 0001h; bits 2:0 code a 2^(n+1) word burst.
// - Burst code 7 means continuous linear burst to end of space.
// - Offset 4Bh reads 0002h, the eight-word burst configuration.
// - Offset 4Ch reads 0007h, the continuous linear burst configuration.
// - Offset 4Eh reads 0001h; wait handshake in synchronous reads only.
// - Offset 47h reads 0000h, reserved entry before burst information.
`timescale 1ns/1ps
module capability_query_table (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [2:0] last_burst_code,
   output logic continuous_burst
);
   // ***************************************************************
   // Local layout of the query store
   // ***************************************************************
   localparam int ROM_AW = 3;
   localparam int ENTRIES = query_table_pkg::ENTRY_COUNT;

   // Store slots of the first and last burst configuration entry
   localparam logic [ROM_AW-1:0] SLOT_CFG_FIRST = ROM_AW'(
      query_table_pkg::IDX_SYNC_CFG_ONE - query_table_pkg::IDX_FIRST);
   localparam logic [ROM_AW-1:0] SLOT_CFG_LAST = ROM_AW'(
      query_table_pkg::IDX_SYNC_CFG_THREE - query_table_pkg::IDX_FIRST);

   // ***************************************************************
   // Types and signals
   // ***************************************************************
   typedef enum logic [1:0] {IDLE, FETCH, ANSWER} state_t;
   typedef enum logic [1:0] {
      KIND_NONE,
      KIND_TABLE,
      KIND_CONTROL,
      KIND_STATUS
   } kind_t;

   state_t state;
   kind_t kind;
   kind_t next_kind;

   logic setup;
   logic access_done;
   logic answer_now;
   logic aligned;
   logic in_window;
   logic in_table;
   logic [7:0] word_index;
   logic [ENTRIES-1:0] entry_hit;
   logic [ROM_AW-1:0] rom_addr;
   logic [15:0] rom_data;
   logic hit_table;
   logic hit_ctrl;
   logic hit_status;
   logic cfg_entry;
   logic refused;
   logic refused_xfer;
   logic cfg_xfer;
   logic write_xfer;
   logic query_en;
   logic ctrl_write;
   logic [31:0] table_word;
   logic [31:0] control_word;
   logic [31:0] status_word;
   logic [31:0] next_prdata;
   logic [2:0] next_burst_code;

   // ***************************************************************
   // Address decode
   // ***************************************************************
   assign setup = psel && !penable;
   assign access_done = psel && penable && pready;
   assign aligned = (paddr[1:0] == 2'b00);
   assign word_index = paddr[9:2];
   assign in_window = aligned && (paddr[11:10] == 2'b00);

   // One comparator per entry; the table is contiguous in the word space
   for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
      assign entry_hit[i] = in_window
         && (word_index == query_table_pkg::IDX_FIRST + 8'(i));
   end

   assign in_table = |entry_hit;
   assign cfg_entry = |entry_hit[SLOT_CFG_LAST:SLOT_CFG_FIRST];
   // Store slots count up from the reserved entry
   assign rom_addr = ROM_AW'(word_index - query_table_pkg::IDX_FIRST);

   // Table entries are read-only and only visible in query mode
   assign hit_table = in_table && query_en && !pwrite;
   // Control takes both directions; status is read-only
   assign hit_ctrl = (paddr == query_table_pkg::ADDR_CONTROL);
   assign hit_status = (paddr == query_table_pkg::ADDR_STATUS) && !pwrite;

   always_comb begin
      if (hit_table) begin
         next_kind = KIND_TABLE;
      end else if (hit_ctrl) begin
         next_kind = KIND_CONTROL;
      end else if (hit_status) begin
         next_kind = KIND_STATUS;
      end else begin
         next_kind = KIND_NONE;
      end
   end

   // Anything that matches no register is refused with an error
   assign refused = (next_kind == KIND_NONE);

   // ***************************************************************
   // Query store
   // ***************************************************************
   query_rom #(
      .DEPTH(ENTRIES),
      .AW(ROM_AW)
   ) u_rom (
      .pclk(pclk),
      .presetn(presetn),
      .addr(rom_addr),
      .rdata(rom_data)
   );

   // ***************************************************************
   // Transfer sequencing: setup, one fetch cycle, then answer
   // ***************************************************************
   // New setups are ignored until the answer has been given
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= IDLE;
      end else begin
         case (state)
            IDLE: begin
               if (setup) begin
                  state <= FETCH;
               end
            end
            FETCH: begin
               if (psel && penable) begin
                  state <= ANSWER;
               end else begin
                  state <= IDLE;
               end
            end
            ANSWER: begin
               state <= IDLE;
            end
            default: begin
               state <= IDLE;
            end
         endcase
      end
   end

   // A master that leaves the access phase early gets no answer
   assign answer_now = (state == FETCH) && psel && penable;

   // Decode is frozen at setup; the store needs the fetch cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         kind <= KIND_NONE;
      end else if (state == IDLE && setup) begin
         kind <= next_kind;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refused_xfer <= 1'b0;
      end else if (state == IDLE && setup) begin
         refused_xfer <= refused;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_xfer <= 1'b0;
      end else if (state == IDLE && setup) begin
         cfg_xfer <= cfg_entry && hit_table;
      end
   end

   // Direction is frozen too, so a late flip cannot make a write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_xfer <= 1'b0;
      end else if (state == IDLE && setup) begin
         write_xfer <= pwrite;
      end
   end

   // ***************************************************************
   // Response flags
   // ***************************************************************
   // Ready is a flop so the answer lands one edge after the fetch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= answer_now;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= answer_now && refused_xfer;
      end
   end

   // ***************************************************************
   // Read data; table words sit in the low half, upper half zero
   // ***************************************************************
   assign table_word = {16'h0000, rom_data};
   assign control_word = {31'h0000_0000, query_en};
   // Status mirrors the captured code so software can copy it back
   assign status_word = {28'h000_0000, continuous_burst, last_burst_code};

   always_comb begin
      next_prdata = 32'h0000_0000;
      if (!refused_xfer) begin
         case (kind)
            KIND_TABLE: begin
               next_prdata = table_word;
            end
            KIND_CONTROL: begin
               next_prdata = control_word;
            end
            KIND_STATUS: begin
               next_prdata = status_word;
            end
            default: begin
               next_prdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // Data is loaded once per transfer and then held for the master
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (answer_now) begin
         prdata <= next_prdata;
      end
   end

   // ***************************************************************
   // Control: query mode enable, written by software
   // ***************************************************************
   // Commit only at the edge where the master sees ready
   assign ctrl_write = (state == ANSWER) && (kind == KIND_CONTROL)
      && access_done && write_xfer;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         query_en <= query_table_pkg::CONTROL_RESET[
            query_table_pkg::CTRL_QUERY_EN_BIT];
      end else if (ctrl_write) begin
         query_en <= pwdata[query_table_pkg::CTRL_QUERY_EN_BIT];
      end
   end

   // ***************************************************************
   // Burst code of the last configuration entry read, kept as-is
   // so it can be copied straight into read configuration bits 2:0
   // ***************************************************************
   assign next_burst_code =
      rom_data[query_table_pkg::BURST_CODE_LSB +:
         query_table_pkg::BURST_CODE_W];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_burst_code <= 3'h0;
      end else if (answer_now && kind == KIND_TABLE && cfg_xfer) begin
         last_burst_code <= next_burst_code;
      end
   end

   // Code 7 is the open-ended linear burst, not a fixed length
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         continuous_burst <= 1'b0;
      end else if (answer_now && kind == KIND_TABLE && cfg_xfer) begin
         continuous_burst <=
            (next_burst_code == query_table_pkg::BURST_CONTINUOUS);
      end
   end
endmodule

/* verilog/query_table_pkg.sv */
// Package of offsets, values and encodings for the burst read query table
package query_table_pkg;
   // ********************************************************************
   // Query offsets (word indices; byte address is four times the index)
   // ********************************************************************
   localparam logic [7:0] IDX_RESERVED = 8'h47;
   localparam logic [7:0] IDX_PAGE_READ = 8'h48;
   localparam logic [7:0] IDX_SYNC_COUNT = 8'h49;
   localparam logic [7:0] IDX_SYNC_CFG_ONE = 8'h4A;
   localparam logic [7:0] IDX_SYNC_CFG_TWO = 8'h4B;
   localparam logic [7:0] IDX_SYNC_CFG_THREE = 8'h4C;
   localparam logic [7:0] IDX_MAX_CLOCK = 8'h4D;
   localparam logic [7:0] IDX_HANDSHAKE = 8'h4E;
   localparam logic [7:0] IDX_FIRST = IDX_RESERVED;
   localparam int ENTRY_COUNT = 8;
   // Control/status registers outside the query range
   localparam logic [11:0] ADDR_CONTROL = 12'h200;
   localparam logic [11:0] ADDR_STATUS = 12'h204;
   // ********************************************************************
   // Entry values
   // ********************************************************************
   localparam logic [15:0] VAL_RESERVED = 16'h0000;
   localparam logic [15:0] VAL_PAGE_READ = 16'h0003;
   localparam logic [15:0] VAL_SYNC_COUNT = 16'h0003;
   localparam logic [15:0] VAL_SYNC_CFG_ONE = 16'h0001;
   localparam logic [15:0] VAL_SYNC_CFG_TWO = 16'h0002;
   localparam logic [15:0] VAL_SYNC_CFG_THREE = 16'h0007;
   localparam logic [15:0] VAL_MAX_CLOCK = 16'h0036;
   localparam logic [15:0] VAL_HANDSHAKE = 16'h0001;
   // ********************************************************************
   // Field layout
   // ********************************************************************
   localparam int BURST_CODE_LSB = 0;
   localparam int BURST_CODE_W = 3;
   localparam logic [2:0] BURST_CONTINUOUS = 3'h7;
   localparam int CTRL_QUERY_EN_BIT = 0;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;
endpackage

/* verilog/query_rom.sv */
// Small registered-output store holding the query table words
`timescale 1ns/1ps
module query_rom #(
   parameter int DEPTH = query_table_pkg::ENTRY_COUNT,
   parameter int AW = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [AW-1:0] addr,
   output logic [15:0] rdata
);
   logic [15:0] table_word [DEPTH];

   // ***************************************************************
   // Table contents, ordered from the reserved entry upward
   // ***************************************************************
   assign table_word[0] = query_table_pkg::VAL_RESERVED;
   assign table_word[1] = query_table_pkg::VAL_PAGE_READ;
   assign table_word[2] = query_table_pkg::VAL_SYNC_COUNT;
   assign table_word[3] = query_table_pkg::VAL_SYNC_CFG_ONE;
   assign table_word[4] = query_table_pkg::VAL_SYNC_CFG_TWO;
   assign table_word[5] = query_table_pkg::VAL_SYNC_CFG_THREE;
   assign table_word[6] = query_table_pkg::VAL_MAX_CLOCK;
   assign table_word[7] = query_table_pkg::VAL_HANDSHAKE;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= table_word[addr];
      end
   end
endmodule

/* verification/query_host.sv */
// Host model issuing APB query reads and writes
`timescale 1ns/1ps
module query_host (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // Called just after an edge; on release paddr and pwdata go inverted, pwrite is left as driven
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

/* verification/query_table_chk.sv */
// Port checker for the capability query table
`timescale 1ns/1ps
module query_table_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [2:0] last_burst_code,
   input wire logic continuous_burst
);
   localparam logic [15:0] TV [8] = '{16'h0000, 16'h0003, 16'h0003,
      16'h0001, 16'h0002, 16'h0007, 16'h0036, 16'h0001};
   logic [11:0] off;
   logic in_tbl;
   logic cfg;
   logic rd_ok;
   assign off = paddr - 12'h11C;
   assign in_tbl = off < 12'h020 && off[1:0] == 2'h0;
   assign cfg = in_tbl && off[4:2] >= 3'h3 && off[4:2] <= 3'h5;
   assign rd_ok = pready && !pwrite && !pslverr;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   a_answer_bound: assert property (s_setup |-> ##[1:3] pready)
      else $error("transfer not answered");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   a_error_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_error_zero: assert property (pslverr |-> prdata == 32'h0)
      else $error("error with nonzero data");
   a_table_value: assert property (rd_ok && in_tbl |->
      prdata == {16'h0000, TV[off[4:2]]})
      else $error("table entry value");
   a_continuous_flag: assert property
      (continuous_burst == (last_burst_code == 3'h7))
      else $error("continuous flag mismatch");
   a_code_update: assert property
      (rd_ok && cfg |-> ##[1:2] last_burst_code == prdata[2:0])
      else $error("burst code not captured");
endmodule
bind capability_query_table query_table_chk u_query_table_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .last_burst_code(last_burst_code), .continuous_burst(continuous_burst));

/* verification/capability_query_table_test.sv */
// Self-checking bench for the capability query table
`timescale 1ns/1ps
module capability_query_table_test;
   localparam logic [15:0] TV [8] = '{16'h0000, 16'h0003, 16'h0003,
      16'h0001, 16'h0002, 16'h0007, 16'h0036, 16'h0001};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, continuous_burst, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] last_burst_code;
   int error_cnt = 0;
   int n_checks = 0;
   always #50 pclk = ~pclk;
   query_host u_query_host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   capability_query_table u_capability_query_table (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .last_burst_code(last_burst_code),
      .continuous_burst(continuous_burst));
   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      u_query_host.xfer(w, a, d, rd, err);
   endtask
   task automatic final_report;
      if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic test_table;
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, 12'h11C + 12'(4 * i), 32'h0);
         check("entry", {16'h0, TV[i]}, rd);
         check("entry error", 32'h0, {31'h0, err});
      end
   endtask
   task automatic test_codes;
      for (int i = 0; i < 3; i++) begin
         bus(1'b0, 12'h128 + 12'(4 * i), 32'h0);
         @(posedge pclk);
         @(negedge pclk);
         check("code", {29'h0, TV[3 + i][2:0]}, {29'h0, last_burst_code});
         check("continuous", {31'h0, i == 2}, {31'h0, continuous_burst});
      end
      bus(1'b0, 12'h204, 32'h0);
      check("status", 32'h0000000F, rd);
   endtask
   task automatic test_refused;
      bus(1'b0, 12'h3F0, 32'h0);
      check("unmapped error", 32'h1, {31'h0, err});
      check("unmapped data", 32'h0, rd);
      bus(1'b1, 12'h120, 32'h0000FFFF);
      check("write error", 32'h1, {31'h0, err});
      bus(1'b0, 12'h120, 32'h0);
      check("after write", 32'h3, rd);
   endtask
   // Query disable makes table reads fail until enabled again
   task automatic test_disable;
      bus(1'b0, 12'h200, 32'h0);
      check("control reset", 32'h1, rd);
      bus(1'b1, 12'h200, 32'h0);
      bus(1'b0, 12'h124, 32'h0);
      check("disabled error", 32'h1, {31'h0, err});
      bus(1'b1, 12'h200, 32'h1);
      bus(1'b0, 12'h124, 32'h0);
      check("enabled entry", 32'h3, rd);
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      test_table();
      test_codes();
      test_refused();
      test_disable();
      final_report();
   end
   initial begin
      #200000;
      error_cnt++;
      final_report();
   end
endmodule
